// File: verilog/gpio_upper_pkg.sv
// Purpose: constants and carriers for the upper pin configuration block
// Assumes: byte-wide register port, one clock at 50 MHz
// Notes: offsets are word indices as printed
package gpio_upper_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned NPINS = 6;
  // Register offsets
  localparam logic [7:0] OFF_CFG_10_11 = 8'h1A;
  localparam logic [7:0] OFF_CFG_12_13 = 8'h1B;
  localparam logic [7:0] OFF_CFG_14_15 = 8'h1C;
  localparam logic [7:0] OFF_MODE = 8'h1E;
  localparam logic [7:0] OFF_WAKE_STAT = 8'h40;
  localparam logic [7:0] OFF_WAKE_MASK = 8'h41;
  localparam logic [7:0] OFF_PIN_STAT = 8'h42;
  // Field positions inside a pair register (odd pin high nibble)
  localparam int unsigned HI_WAKE = 7;
  localparam int unsigned HI_POL = 6;
  localparam int unsigned HI_FN = 4;
  localparam int unsigned LO_WAKE = 3;
  localparam int unsigned LO_POL = 2;
  localparam int unsigned LO_FN = 0;
  // Mode register bits for pins 10..15 start at bit 2
  localparam int unsigned MODE_BASE = 2;
  // Reset values
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] ZERO8 = 8'h00;
  // Function codes
  localparam logic [1:0] FN_00 = 2'h0;
  localparam logic [1:0] FN_01 = 2'h1;
  localparam logic [1:0] FN_10 = 2'h2;
  localparam logic [1:0] FN_11 = 2'h3;
  // Debounce time and blink half period
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned DEB_US = 10;
  localparam int unsigned DEB_CYC = DEB_US * (CLK_HZ / 1000000);
  localparam int unsigned BLINK_MS = 250;
  localparam int unsigned BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);

  typedef struct packed {
    logic wake_mask;
    logic polarity;
    logic [1:0] func;
  } pin_cfg_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage : gpio_upper_pkg

// File: verilog/pin_input_filter.sv
// Purpose: polarity, optional debounce and wake edge for one pin
// Assumes: pin input synchronous to the clock
// Notes: one instance per pin
`timescale 1ns/1ns
`default_nettype none
module pin_input_filter import gpio_upper_pkg::*; #(
  parameter int unsigned DEB_CYCLES = DEB_CYC
) (
  input wire logic clock_i, // System clock
  input wire logic srst_i, // Sync reset
  input wire logic pin_i, // Raw pin level
  input wire logic polarity_i, // 1 active high
  input wire logic debounce_i, // Debounce enable
  input wire logic wake_mask_i, // 1 suppresses wake
  output logic active_o, // Filtered active level
  output logic wake_o // One-cycle wake pulse
);
  localparam int unsigned CW = $clog2(DEB_CYCLES + 1);
  initial begin
    if (DEB_CYCLES < 1) $error("debounce count must be at least one");
  end
  logic sync1_q, sync2_q, stable_q, prev_q, wake_q;
  logic [CW-1:0] cnt_q;
  // Active level after polarity
  wire logic act_w = polarity_i ? sync2_q : ~sync2_q;
  wire logic done_w = (cnt_q == CW'(DEB_CYCLES - 1));
  // Held value follows input at once, or after a quiet time when debouncing
  always_ff @(posedge clock_i) begin
    sync1_q <= srst_i ? ~polarity_i : pin_i; // Passive level, so no false wake after reset
    sync2_q <= srst_i ? ~polarity_i : sync1_q;
    if (srst_i) begin
      stable_q <= 1'b0;
      cnt_q <= '0;
    end else if (!debounce_i || act_w == stable_q) begin
      stable_q <= act_w;
      cnt_q <= '0;
    end else if (done_w) begin
      stable_q <= act_w;
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
  // Passive to active edge against previous sample
  always_ff @(posedge clock_i) begin
    prev_q <= srst_i ? 1'b0 : stable_q;
    wake_q <= srst_i ? 1'b0 : (stable_q & ~prev_q & ~wake_mask_i);
  end
  assign active_o = stable_q;
  assign wake_o = wake_q;
endmodule : pin_input_filter
`default_nettype wire

// File: verilog/gpio_upper_pins.sv
// Purpose: configuration and function selection for pins 10 to 15
// Assumes: register port with read data one cycle after the strobe
// Notes: pins are three signals each; enable high while driving
//
// The strobed register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module gpio_upper_pins import gpio_upper_pkg::*; #(
  parameter int unsigned DEB_CYCLES = DEB_CYC,
  parameter int unsigned BLINK_CYCLES = BLINK_CYC
) (
  input wire logic clock_i, // 50 MHz clock
  input wire logic srst_i, // Sync reset, active high
  input wire logic [ADDR_W-1:0] addr_i, // Register address
  input wire logic [7:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [7:0] rdata_o, // Read data, cycle after strobe
  input wire logic [NPINS-1:0] pin_i, // Pin levels, bit 0 is pin 10
  output logic [NPINS-1:0] pin_o, // Pin drive levels
  output logic [NPINS-1:0] pin_oe_o, // Pin drive enables
  output logic [NPINS-1:0] pin_supply2_o, // Output from second IO supply
  input wire logic seq_out_i, // Sequencer level for pin 11
  input wire logic feedback_i, // General feedback one state
  input wire logic supply_fault_i, // Supply fault state, active high
  input wire logic vsys_mon_i, // System voltage monitor state
  input wire logic tw_sda_o_i, // Two-wire data drive (low when 0)
  input wire logic tw_scl_o_i, // Two-wire clock drive (low when 0)
  output logic tw_sel_o, // Two-wire interface selected
  output logic tw_sda_i_o, // Two-wire data level seen
  output logic tw_scl_i_o, // Two-wire clock level seen
  output logic secondary_power_enable_o, // Secondary power enable request
  output logic reg_hw_ctrl_o, // Pin 13 regulator control input
  output logic [NPINS-1:0] wake_o, // Wake pulses per pin
  output logic irq_o // Level interrupt
);
  initial begin
    if (BLINK_CYCLES < 2) $error("blink count too small");
  end
  localparam int unsigned BW = $clog2(BLINK_CYCLES);

  logic [7:0] cfg_q [3];
  logic [NPINS-1:0] mode_q, wstat_q, wmask_q;
  logic [7:0] rdata_q;
  logic [BW-1:0] bcnt_q;
  logic blink_q;
  logic [NPINS-1:0] pin_q, oe_q, sup_q, wake_q;
  logic tw_sel_q, sda_q, scl_q, pwr1_q, hwc_q, irq_q;
  pin_cfg_t cfg [NPINS];
  logic [NPINS-1:0] act, wk;
  reg_req_t req;

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // Per pin config fields out of the pair registers
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_split
      assign cfg[2*g] = '{wake_mask: cfg_q[g][LO_WAKE], polarity: cfg_q[g][LO_POL],
                          func: cfg_q[g][LO_FN +: 2]};
      assign cfg[2*g+1] = '{wake_mask: cfg_q[g][HI_WAKE], polarity: cfg_q[g][HI_POL],
                            func: cfg_q[g][HI_FN +: 2]};
    end
    for (g = 0; g < NPINS; g++) begin : g_in
      pin_input_filter #(.DEB_CYCLES(DEB_CYCLES)) u_filt (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .pin_i(pin_i[g]),
        .polarity_i(cfg[g].polarity),
        .debounce_i(mode_q[g]),
        .wake_mask_i(cfg[g].wake_mask),
        .active_o(act[g]),
        .wake_o(wk[g])
      );
    end
  endgenerate

  // Register decode
  wire logic sel_cfg10 = (req.addr == OFF_CFG_10_11);
  wire logic sel_cfg12 = (req.addr == OFF_CFG_12_13);
  wire logic sel_cfg14 = (req.addr == OFF_CFG_14_15);
  wire logic sel_mode = (req.addr == OFF_MODE);
  wire logic sel_wst = (req.addr == OFF_WAKE_STAT);
  wire logic sel_wmk = (req.addr == OFF_WAKE_MASK);
  wire logic sel_pst = (req.addr == OFF_PIN_STAT);
  wire logic [NPINS-1:0] wdat6 = req.wdata[NPINS-1:0];
  // Status bits: pin 10 always reports its filtered input, pin 13 by code
  wire logic st10 = act[0];
  wire logic st13 = (cfg[3].func == FN_01) ? act[3] : feedback_i;
  wire logic [NPINS-1:0] pst_w = {act[5], act[4], st13, act[2], act[1], st10};
  wire logic [7:0] rd_w =
    sel_cfg10 ? cfg_q[0] :
    sel_cfg12 ? cfg_q[1] :
    sel_cfg14 ? cfg_q[2] :
    sel_mode ? {mode_q, 2'h0} :
    sel_wst ? {2'h0, wstat_q} :
    sel_wmk ? {2'h0, wmask_q} :
    sel_pst ? {2'h0, pst_w} : ZERO8;

  // Register writes and read data; unmapped reads return zero
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cfg_q[0] <= CFG_RST;
      cfg_q[1] <= CFG_RST;
      cfg_q[2] <= CFG_RST;
      mode_q <= '0;
      wmask_q <= '0;
      rdata_q <= ZERO8;
    end else begin
      if (req.wr && sel_cfg10) cfg_q[0] <= req.wdata;
      if (req.wr && sel_cfg12) cfg_q[1] <= req.wdata;
      if (req.wr && sel_cfg14) cfg_q[2] <= req.wdata;
      if (req.wr && sel_mode) mode_q <= req.wdata[MODE_BASE +: NPINS];
      if (req.wr && sel_wmk) wmask_q <= wdat6;
      rdata_q <= req.rd ? rd_w : ZERO8;
    end
  end

  // Wake status is sticky, write one clears, a new event wins
  always_ff @(posedge clock_i) begin
    if (srst_i) wstat_q <= '0;
    else wstat_q <= (wstat_q & ~((req.wr && sel_wst) ? wdat6 : '0)) | wk;
  end

  // Free running blink square wave
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      bcnt_q <= '0;
      blink_q <= 1'b0;
    end else if (bcnt_q == BW'(BLINK_CYCLES - 1)) begin
      bcnt_q <= '0;
      blink_q <= ~blink_q;
    end else begin
      bcnt_q <= bcnt_q + 1'b1;
    end
  end

  // Output function selection per pin; level and enable
  logic [NPINS-1:0] lvl_d, oe_d;
  wire logic blk10 = blink_q ^ mode_q[1];
  wire logic blk14 = blink_q ^ mode_q[4];
  wire logic blk15 = blink_q ^ mode_q[5];
  wire logic fb_lvl = feedback_i ~^ mode_q[3]; // Mode bit sets feedback polarity
  wire logic tw_on = (cfg[4].func == FN_10);
  always_comb begin
    lvl_d = '0;
    oe_d = '0;
    // Pin 10
    unique case (cfg[0].func)
      FN_00, FN_01: oe_d[0] = 1'b0;
      FN_10: begin lvl_d[0] = 1'b0; oe_d[0] = ~mode_q[0]; end
      FN_11: begin lvl_d[0] = mode_q[0]; oe_d[0] = 1'b1; end
    endcase
    // Pin 11, open drain blinking pulls low in the active phase
    unique case (cfg[1].func)
      FN_00: begin lvl_d[1] = 1'b0; oe_d[1] = ~blk10; end
      FN_01: oe_d[1] = 1'b0;
      FN_10: begin lvl_d[1] = seq_out_i ~^ mode_q[1]; oe_d[1] = 1'b1; end
      FN_11: begin lvl_d[1] = mode_q[1]; oe_d[1] = 1'b1; end
    endcase
    // Pin 12
    unique case (cfg[2].func)
      FN_00: begin lvl_d[2] = supply_fault_i ~^ mode_q[2]; oe_d[2] = 1'b1; end // Mode 0 low on fault
      FN_01: oe_d[2] = 1'b0;
      FN_10: begin lvl_d[2] = vsys_mon_i ~^ mode_q[2]; oe_d[2] = 1'b1; end
      FN_11: begin lvl_d[2] = mode_q[2]; oe_d[2] = 1'b1; end
    endcase
    // Pin 13
    unique case (cfg[3].func)
      FN_00: begin lvl_d[3] = fb_lvl; oe_d[3] = 1'b1; end
      FN_01: oe_d[3] = 1'b0;
      FN_10: begin lvl_d[3] = 1'b0; oe_d[3] = ~fb_lvl; end
      FN_11: begin lvl_d[3] = mode_q[3]; oe_d[3] = 1'b1; end
    endcase
    // Pin 14, data line is open drain
    unique case (cfg[4].func)
      FN_00: begin lvl_d[4] = 1'b0; oe_d[4] = ~blk14; end
      FN_01: oe_d[4] = 1'b0;
      FN_10: begin lvl_d[4] = 1'b0; oe_d[4] = ~tw_sda_o_i; end
      FN_11: begin lvl_d[4] = mode_q[4]; oe_d[4] = 1'b1; end
    endcase
    // Pin 15, clock role follows pin 14's selection
    if (tw_on) begin
      lvl_d[5] = 1'b0;
      oe_d[5] = ~tw_scl_o_i;
    end else begin
      unique case (cfg[5].func)
        FN_00: begin lvl_d[5] = 1'b0; oe_d[5] = ~blk15; end
        FN_01, FN_10: oe_d[5] = 1'b0;
        FN_11: begin lvl_d[5] = 1'b0; oe_d[5] = ~mode_q[5]; end
      endcase
    end
  end

  // Registered pin and side outputs
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pin_q <= '0;
      oe_q <= '0;
      sup_q <= '0;
      wake_q <= '0;
      tw_sel_q <= 1'b0;
      sda_q <= 1'b1;
      scl_q <= 1'b1;
      pwr1_q <= 1'b0;
      hwc_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      pin_q <= lvl_d;
      oe_q <= oe_d;
      for (int i = 0; i < NPINS; i++) sup_q[i] <= cfg[i].polarity;
      wake_q <= wk;
      tw_sel_q <= tw_on;
      sda_q <= pin_i[4];
      scl_q <= pin_i[5];
      pwr1_q <= (cfg[0].func == FN_00) & act[0];
      hwc_q <= (cfg[3].func == FN_01) & act[3];
      irq_q <= |(wstat_q & ~wmask_q);
    end
  end

  assign rdata_o = rdata_q;
  assign pin_o = pin_q;
  assign pin_oe_o = oe_q;
  assign pin_supply2_o = sup_q;
  assign wake_o = wake_q;
  assign tw_sel_o = tw_sel_q;
  assign tw_sda_i_o = sda_q;
  assign tw_scl_i_o = scl_q;
  assign secondary_power_enable_o = pwr1_q;
  assign reg_hw_ctrl_o = hwc_q;
  assign irq_o = irq_q;

  // Checks
  sequence s_tw_pick;
    srst_i == 1'b0 && cfg[4].func == FN_10;
  endsequence
  tw_select_a: assert property (@(posedge clock_i) disable iff (srst_i)
    s_tw_pick |=> tw_sel_o) else $error("two-wire select missing");
  p11_mode_a: assert property (@(posedge clock_i) disable iff (srst_i)
    cfg[1].func == FN_11 |=> pin_oe_o[1] && pin_o[1] == $past(mode_q[1]))
    else $error("pin 11 mode level wrong");
  p10_input_a: assert property (@(posedge clock_i) disable iff (srst_i)
    cfg[0].func == FN_01 |=> !pin_oe_o[0]) else $error("pin 10 input driven");
  p13_fb_a: assert property (@(posedge clock_i) disable iff (srst_i)
    cfg[3].func == FN_00 |=> pin_oe_o[3] && pin_o[3] == $past(fb_lvl))
    else $error("pin 13 feedback level wrong");
  p12_vsys_a: assert property (@(posedge clock_i) disable iff (srst_i)
    cfg[2].func == FN_10 && mode_q[2] |=> pin_o[2] == $past(vsys_mon_i))
    else $error("pin 12 monitor level wrong");
  p15_in_a: assert property (@(posedge clock_i) disable iff (srst_i)
    cfg[5].func == FN_01 && !tw_on |=> !pin_oe_o[5]) else $error("pin 15 input driven");
  wake_sticky_a: assert property (@(posedge clock_i) disable iff (srst_i)
    |wk |=> |wstat_q) else $error("wake event lost");
  irq_level_a: assert property (@(posedge clock_i) disable iff (srst_i)
    |(wstat_q & ~wmask_q) |=> irq_o) else $error("interrupt not raised");
  supply_sel_a: assert property (@(posedge clock_i) disable iff (srst_i)
    1'b1 |=> pin_supply2_o[0] == $past(cfg[0].polarity)) else $error("supply select wrong");
  // Pin drive checks; an active low fault output must pull the pin down
  p12_fault_a: assert property (@(posedge clock_i) disable iff (srst_i)
    cfg[2].func == FN_00 && !mode_q[2] && supply_fault_i |=> pin_oe_o[2] && !pin_o[2])
    else $error("pin 12 fault level wrong");
  p10_od_a: assert property (@(posedge clock_i) disable iff (srst_i)
    cfg[0].func == FN_10 |=> !pin_o[0]) else $error("pin 10 open drain driven high");
  p11_in_a: assert property (@(posedge clock_i) disable iff (srst_i)
    cfg[1].func == FN_01 |=> !pin_oe_o[1]) else $error("pin 11 input driven");
  p14_in_a: assert property (@(posedge clock_i) disable iff (srst_i)
    cfg[4].func == FN_01 |=> !pin_oe_o[4]) else $error("pin 14 input driven");
  sequence s_tw_clk_low;
    tw_on && !tw_scl_o_i;
  endsequence
  p15_clk_a: assert property (@(posedge clock_i) disable iff (srst_i)
    s_tw_clk_low |=> pin_oe_o[5] && !pin_o[5]) else $error("pin 15 clock not pulled");
  blink_phase_a: assert property (@(posedge clock_i) disable iff (srst_i)
    cfg[1].func == FN_00 && cfg[4].func == FN_00 && mode_q[1] != mode_q[4]
    |=> pin_oe_o[1] != pin_oe_o[4]) else $error("blink phase not inverted");
  // Side outputs and wake checks
  pwr_code_a: assert property (@(posedge clock_i) disable iff (srst_i)
    cfg[0].func != FN_00 |=> !secondary_power_enable_o) else $error("power enable outside its code");
  p13_hw_a: assert property (@(posedge clock_i) disable iff (srst_i)
    cfg[3].func != FN_01 |=> !reg_hw_ctrl_o) else $error("regulator control outside its code");
  wake_pulse_a: assert property (@(posedge clock_i) disable iff (srst_i)
    (wake_o & $past(wake_o)) == '0) else $error("wake pulse too long");
  wake_mask_a: assert property (@(posedge clock_i) disable iff (srst_i)
    cfg[0].wake_mask |-> ##2 !wake_o[0]) else $error("masked wake seen");
endmodule : gpio_upper_pins
`default_nettype wire

// File: test/pin_pad_model.sv
// Purpose: board side of pins 10 to 15, resolving each pad level
// Assumes: every pad carries a board pull-up
// Notes: device drive wins over board drive; contention is not modelled
`timescale 1ns/1ns
`default_nettype none
module pin_pad_model (
  input wire logic [5:0] drv_i, // Device drive level
  input wire logic [5:0] drv_en_i, // Device drive enable
  input wire logic [5:0] ext_i, // Board drive level
  input wire logic [5:0] ext_en_i, // Board drive enable
  output logic [5:0] pad_o // Resolved pad level
);
  // Released pads rise through the pull-up, never keep the old level
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      pad_o[k] = drv_en_i[k] ? drv_i[k] : (ext_en_i[k] ? ext_i[k] : 1'h1);
    end
  end
endmodule : pin_pad_model
`default_nettype wire

// File: test/gpio_upper_pins_tb.sv
// Purpose: self-checking bench for the upper pin configuration block
// Assumes: short debounce and blink counts, board pull-ups on all pads
// Notes: blink phase is judged between pins, not against absolute time
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin err_total++; \
  $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module gpio_upper_pins_tb;
  import gpio_upper_pkg::*;
  logic clock_i = 1'h0;
  logic srst_i = 1'h1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'h0;
  logic rd_i = 1'h0;
  logic [5:0] ext_val = 6'h00;
  logic [5:0] ext_en = 6'h01;
  logic seq_out_i = 1'h0;
  logic feedback_i = 1'h0;
  logic supply_fault_i = 1'h0;
  logic vsys_mon_i = 1'h0;
  logic tw_sda_o_i = 1'h1;
  logic tw_scl_o_i = 1'h1;
  wire [7:0] rdata_o;
  wire [5:0] pad, pin_o, pin_oe_o, pin_supply2_o, wake_o;
  wire tw_sel_o, tw_sda_i_o, tw_scl_i_o, secondary_power_enable_o, reg_hw_ctrl_o, irq_o;
  int err_total = 0;
  int check_count = 0;
  logic [7:0] rd_val;
  logic seen;

  // Clock at 50 MHz
  always #10 clock_i = ~clock_i;

  gpio_upper_pins #(.DEB_CYCLES(4), .BLINK_CYCLES(8)) i_gpio_upper_pins (
    .clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pad), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .pin_supply2_o(pin_supply2_o), .seq_out_i(seq_out_i),
    .feedback_i(feedback_i), .supply_fault_i(supply_fault_i), .vsys_mon_i(vsys_mon_i),
    .tw_sda_o_i(tw_sda_o_i), .tw_scl_o_i(tw_scl_o_i), .tw_sel_o(tw_sel_o),
    .tw_sda_i_o(tw_sda_i_o), .tw_scl_i_o(tw_scl_i_o), .secondary_power_enable_o(secondary_power_enable_o),
    .reg_hw_ctrl_o(reg_hw_ctrl_o), .wake_o(wake_o), .irq_o(irq_o));

  pin_pad_model i_pin_pad_model (.drv_i(pin_o), .drv_en_i(pin_oe_o), .ext_i(ext_val),
    .ext_en_i(ext_en), .pad_o(pad));

  // Register port cycles, strobes one cycle wide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'h1;
    @(posedge clock_i);
    wr_i <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'h1;
    @(posedge clock_i);
    rd_i <= 1'h0;
    #1;
    rd_val = rdata_o;
  endtask : rd
  // Wait past the register to pin latency plus the input filter
  task automatic settle();
    repeat (8) @(posedge clock_i);
    #1;
  endtask : settle
  task automatic pin(input int k, input logic v);
    @(posedge clock_i);
    ext_val[k] <= v;
  endtask : pin
  task automatic wait_wake(input int k);
    seen = 1'h0;
    repeat (12) begin
      @(posedge clock_i);
      #1;
      if (wake_o[k] === 1'h1) seen = 1'h1;
    end
  endtask : wait_wake

  // Reset values, read back, unmapped address
  task automatic t_regs();
    logic [7:0] offs [3] = '{OFF_CFG_10_11, OFF_CFG_12_13, OFF_CFG_14_15};
    foreach (offs[i]) begin
      rd(offs[i]);
      `CHK("cfg reset", CFG_RST, rd_val)
      wr(offs[i], 8'h5A);
      rd(offs[i]);
      `CHK("cfg readback", 8'h5A, rd_val)
      wr(offs[i], 8'h00);
    end
    wr(8'h33, 8'hFF);
    rd(8'h33);
    `CHK("unmapped", 8'h00, rd_val)
  endtask : t_regs

  // Mode driven outputs on every pin, supply select
  task automatic t_outputs();
    wr(OFF_MODE, 8'hFC);
    wr(OFF_CFG_10_11, 8'h33);
    wr(OFF_CFG_12_13, 8'h33);
    wr(OFF_CFG_14_15, 8'h03);
    settle();
    `CHK("mode oe", 5'h1F, pin_oe_o[4:0])
    `CHK("mode high", 5'h1F, pin_o[4:0])
    wr(OFF_MODE, 8'h00);
    wr(OFF_CFG_14_15, 8'h33);
    settle();
    `CHK("mode low", 5'h00, pin_o[4:0])
    `CHK("p15 od low", 2'h2, {pin_oe_o[5], pin_o[5]})
    wr(OFF_MODE, 8'h80);
    wr(OFF_CFG_10_11, 8'h77);
    settle();
    `CHK("p15 od free", 1'h0, pin_oe_o[5])
    `CHK("supply two", 2'h3, pin_supply2_o[1:0])
  endtask : t_outputs

  // Wake on passive to active, mask, polarity, sticky status and irq
  task automatic t_wake();
    wr(OFF_MODE, 8'h00);
    wr(OFF_WAKE_MASK, 8'hFE);
    wr(OFF_CFG_10_11, 8'h05);
    settle();
    wr(OFF_WAKE_STAT, 8'hFF);
    pin(0, 1'h1);
    wait_wake(0);
    `CHK("wake rise", 1'h1, seen)
    `CHK("irq set", 1'h1, irq_o)
    rd(OFF_WAKE_STAT);
    `CHK("stat bit", 1'h1, rd_val[0])
    wr(OFF_WAKE_STAT, 8'h01);
    settle();
    `CHK("irq clear", 1'h0, irq_o)
    pin(0, 1'h0);
    wait_wake(0);
    `CHK("no wake fall", 1'h0, seen)
    wr(OFF_CFG_10_11, 8'h0D);
    pin(0, 1'h1);
    wait_wake(0);
    `CHK("wake masked", 1'h0, seen)
    wr(OFF_CFG_10_11, 8'h01);
    settle();
    pin(0, 1'h0);
    wait_wake(0);
    `CHK("wake low act", 1'h1, seen)
  endtask : t_wake

  // Secondary power enable and its polarity
  task automatic t_pwr();
    wr(OFF_CFG_10_11, 8'h04);
    pin(0, 1'h1);
    settle();
    `CHK("pwr high", 1'h1, secondary_power_enable_o)
    wr(OFF_CFG_10_11, 8'h00);
    settle();
    `CHK("pwr inverse", 1'h0, secondary_power_enable_o)
    pin(0, 1'h0);
    settle();
    `CHK("pwr low", 1'h1, secondary_power_enable_o)
    rd(OFF_PIN_STAT);
    `CHK("pwr stat", 1'h1, rd_val[0])
  endtask : t_pwr

  // Feedback, regulator control, monitor and sequencer sources
  task automatic t_fb();
    wr(OFF_MODE, 8'h38);
    feedback_i <= 1'h1;
    vsys_mon_i <= 1'h1;
    seq_out_i <= 1'h1;
    wr(OFF_CFG_12_13, 8'h02);
    wr(OFF_CFG_10_11, 8'h20);
    settle();
    `CHK("fb pp", 2'h3, {pin_oe_o[3], pin_o[3]})
    `CHK("vsys pp", 2'h3, {pin_oe_o[2], pin_o[2]})
    `CHK("seq pp", 2'h3, {pin_oe_o[1], pin_o[1]})
    wr(OFF_CFG_12_13, 8'h22);
    settle();
    `CHK("fb od free", 1'h0, pin_oe_o[3])
    feedback_i <= 1'h0;
    vsys_mon_i <= 1'h0;
    seq_out_i <= 1'h0;
    settle();
    `CHK("fb od low", 2'h2, {pin_oe_o[3], pin_o[3]})
    `CHK("vsys low", 1'h0, pin_o[2])
    `CHK("seq low", 1'h0, pin_o[1])
    ext_en[3] <= 1'h1;
    ext_val[3] <= 1'h1;
    wr(OFF_CFG_12_13, 8'h50);
    settle();
    `CHK("hw ctrl", 1'h1, reg_hw_ctrl_o)
    rd(OFF_PIN_STAT);
    `CHK("p13 stat", 1'h1, rd_val[3])
    `CHK("fault idle", 2'h2, {pin_oe_o[2], pin_o[2]})
    supply_fault_i <= 1'h1;
    settle();
    `CHK("fault high", 1'h1, pin_o[2])
    wr(OFF_MODE, 8'h28);
    settle();
    `CHK("fault low", 1'h0, pin_o[2])
  endtask : t_fb

  // Two-wire interface takes pins 14 and 15
  task automatic t_twowire();
    wr(OFF_CFG_14_15, 8'h02);
    settle();
    `CHK("tw sel", 1'h1, tw_sel_o)
    `CHK("tw idle", 2'h3, {tw_sda_i_o, tw_scl_i_o})
    tw_sda_o_i <= 1'h0;
    tw_scl_o_i <= 1'h0;
    settle();
    `CHK("tw pull", 4'hA, {pin_oe_o[4], pin_o[4], pin_oe_o[5], pin_o[5]})
    `CHK("tw seen", 2'h0, {tw_sda_i_o, tw_scl_i_o})
    wr(OFF_CFG_14_15, 8'h11);
    settle();
    `CHK("tw off", 1'h0, tw_sel_o)
    `CHK("p14 p15 in", 2'h0, pin_oe_o[5:4])
  endtask : t_twowire

  // Blink phase follows each pin's mode bit; half period is the bench's 8 cycles
  task automatic t_blink();
    logic [7:0] n_on, n_inv, n_same;
    n_on = 8'h00;
    n_inv = 8'h00;
    n_same = 8'h00;
    wr(OFF_MODE, 8'h40);
    wr(OFF_CFG_10_11, 8'h00);
    wr(OFF_CFG_14_15, 8'h00);
    settle();
    repeat (32) begin
      @(posedge clock_i);
      #1;
      n_on = n_on + pin_oe_o[1];
      n_inv = n_inv + (pin_oe_o[4] != pin_oe_o[1]);
      n_same = n_same + (pin_oe_o[5] == pin_oe_o[1]);
    end
    `CHK("blink duty", 8'h10, n_on)
    `CHK("blink inverse", 8'h20, n_inv)
    `CHK("blink same", 8'h20, n_same)
    `CHK("blink od", 3'h0, {pin_o[5], pin_o[4], pin_o[1]})
  endtask : t_blink

  task automatic conclude();
    $display("Checks %0d, errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  // Main sequence after two reset cycles
  initial begin
    repeat (2) @(posedge clock_i);
    srst_i <= 1'h0;
    t_regs();
    t_outputs();
    t_wake();
    t_pwr();
    t_fb();
    t_twowire();
    t_blink();
    conclude();
  end

  // Watchdog well beyond the expected run of a few hundred cycles
  initial begin
    #400000;
    err_total++;
    conclude();
  end
endmodule : gpio_upper_pins_tb
`default_nettype wire
